//--- hdl/serial_eeprom_pin_control.sv
`timescale 1ns/10ps
module serial_eeprom_pin_control
   import eeprom_pin_pkg::*;
#(
   parameter int WRITE_CYCLES = TWC_CYCLES
) (
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic I_SI,
   input wire logic I_HOLD_N,
   input wire logic I_WP_N,
   output logic O_SO,
   output logic O_SO_OE,
   output logic O_WRITE_BUSY,
   output logic O_WRITE_LATCH,
   output logic O_STANDBY
);

   // storage shared by both sides
   logic [7:0] mem_reg [MEM_BYTES];
   logic [7:0] mem_next [MEM_BYTES];

   // link side, frame state (cleared while deselected)
   link_state_e lstate_reg, lstate_next;
   logic [2:0] bitn_reg, bitn_next;

   // link side, sequence record kept after the frame
   logic [7:0] shift_reg, shift_next;
   logic [7:0] opcode_reg, opcode_next;
   logic [8:0] addr_reg, addr_next;
   logic [7:0] pbuf_reg [PAGE_BYTES];
   logic [7:0] pbuf_next [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] valid_reg, valid_next;
   logic armed_reg, armed_next;
   logic tog_reg, tog_next;

   // link side, output stage on the falling edge
   logic so_reg, so_next;
   logic oe_reg, oe_next;
   logic so_clr;

   // reference side
   prog_state_e pstate_reg, pstate_next;
   logic [TWC_CNT_W-1:0] cnt_reg, cnt_next;
   logic latch_reg, latch_next;
   logic [1:0] bp_reg, bp_next;
   logic busy_reg, busy_next;
   logic standby_reg, standby_next;
   logic seen_low_reg, seen_low_next;
   logic last_tog_reg, last_tog_next;
   logic cs_prev_reg, cs_prev_next;

   link_flags_s flags_async, flags_ref;
   dev_status_s stat_async, stat_link;

   logic [7:0] sh;
   logic byte_done;
   logic [7:0] out_byte;
   logic cs_rise;
   logic commit;
   logic [4:0] page;

   // crossings: levels only; the page buffer, address and opcode are
   // read by the reference side after select rises, when the serial
   // clock has stopped, so they are stable by then
   assign flags_async = '{cs_n: I_CS_N, wp_n: I_WP_N, armed: armed_reg, frame_tog: tog_reg};
   assign stat_async = '{bp: bp_reg, latch: latch_reg, busy: busy_reg};

   level_sync2 #(.WIDTH($bits(link_flags_s))) u_to_ref (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_async(flags_async),
      .o_sync(flags_ref)
   );

   level_sync2 #(.WIDTH($bits(dev_status_s))) u_to_link (
      .i_clk(I_SCK),
      .i_rst_n(I_RST_N),
      .i_async(stat_async),
      .o_sync(stat_link)
   );

   // link side: rising-edge capture
   always_comb begin
      lstate_next = lstate_reg;
      bitn_next = bitn_reg;
      shift_next = shift_reg;
      opcode_next = opcode_reg;
      addr_next = addr_reg;
      pbuf_next = pbuf_reg;
      valid_next = valid_reg;
      armed_next = armed_reg;
      tog_next = tog_reg;
      sh = {shift_reg[6:0], I_SI};
      byte_done = (bitn_reg == 3'h7);
      if (I_HOLD_N) begin // paused edges are ignored
         shift_next = sh;
         bitn_next = bitn_reg + 3'h1;
         // any bit off a byte boundary spoils a pending commit
         armed_next = 1'b0;
         if (lstate_reg == L_CMD && bitn_reg == 3'h0) begin
            tog_next = ~tog_reg;
            valid_next = '0;
         end
         unique case (lstate_reg)
            L_CMD: begin
               if (byte_done) begin
                  opcode_next = sh;
                  addr_next = {sh[3], addr_reg[7:0]};
                  if (op_is_read(sh) || op_is_write(sh)) begin
                     lstate_next = L_ADDR;
                  end else if (sh == OP_READ_STATUS) begin
                     lstate_next = L_STAT;
                  end else if (sh == OP_WRITE_STATUS) begin
                     lstate_next = L_WSR;
                  end else begin
                     lstate_next = L_IGN;
                     armed_next = (sh == OP_SET_WRITE_LATCH) ||
                                  (sh == OP_CLR_WRITE_LATCH);
                  end
               end
            end
            L_ADDR: begin
               if (byte_done) begin
                  addr_next = {addr_reg[8], sh};
                  lstate_next = op_is_read(opcode_reg) ? L_DOUT : L_DIN;
               end
            end
            L_DIN: begin
               if (byte_done) begin
                  pbuf_next[addr_reg[3:0]] = sh;
                  valid_next[addr_reg[3:0]] = 1'b1;
                  // stay inside the page; later bytes overwrite earlier ones
                  addr_next = {addr_reg[8:4], addr_reg[3:0] + 4'h1};
                  armed_next = 1'b1;
               end
            end
            L_WSR: begin
               if (byte_done) begin
                  pbuf_next[0] = sh;
                  armed_next = 1'b1;
                  lstate_next = L_IGN;
               end
            end
            L_DOUT: begin
               if (byte_done) begin
                  addr_next = addr_reg + 9'h001;
               end
            end
            L_STAT, L_IGN: begin
            end
         endcase
      end
   end

   // frame state is held clear while deselected
   always_ff @(posedge I_SCK or posedge I_CS_N) begin
      if (I_CS_N) begin
         lstate_reg <= L_CMD;
         bitn_reg <= 3'h0;
      end else begin
         lstate_reg <= lstate_next;
         bitn_reg <= bitn_next;
      end
   end

   always_ff @(posedge I_SCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         shift_reg <= 8'h00;
         opcode_reg <= 8'h00;
         addr_reg <= 9'h000;
         pbuf_reg <= '{default: 8'h00};
         valid_reg <= '0;
         armed_reg <= 1'b0;
         tog_reg <= 1'b0;
      end else if (!I_CS_N) begin
         shift_reg <= shift_next;
         opcode_reg <= opcode_next;
         addr_reg <= addr_next;
         pbuf_reg <= pbuf_next;
         valid_reg <= valid_next;
         armed_reg <= armed_next;
         tog_reg <= tog_next;
      end
   end

   // link side: falling-edge output
   always_comb begin
      if (lstate_reg == L_STAT) begin
         out_byte = 8'h00;
         out_byte[ST_BUSY_BIT] = stat_link.busy;
         out_byte[ST_LATCH_BIT] = stat_link.latch;
         out_byte[ST_BP_LSB +: 2] = stat_link.bp;
      end else if (stat_link.busy) begin
         // array unreadable while programming
         out_byte = READ_BUSY_BYTE;
      end else begin
         out_byte = mem_reg[addr_reg];
      end
      so_next = out_byte[3'h7 - bitn_reg];
      oe_next = (lstate_reg == L_DOUT) || (lstate_reg == L_STAT);
   end

   // deselect or pause floats the output at once
   assign so_clr = I_CS_N | ~I_HOLD_N;

   always_ff @(negedge I_SCK or posedge so_clr) begin
      if (so_clr) begin
         so_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         so_reg <= so_next;
         oe_reg <= oe_next;
      end
   end

   // reference side: commit and self-timed write
   assign page = addr_reg[8:4];

   always_comb begin
      pstate_next = pstate_reg;
      cnt_next = cnt_reg;
      latch_next = latch_reg;
      bp_next = bp_reg;
      mem_next = mem_reg;
      // a real fall only: the synchroniser shows low for two cycles after reset
      seen_low_next = seen_low_reg | (cs_prev_reg & ~flags_ref.cs_n);
      cs_prev_next = flags_ref.cs_n;
      cs_rise = flags_ref.cs_n & ~cs_prev_reg;
      last_tog_next = cs_rise ? flags_ref.frame_tog : last_tog_reg;
      // a frame with no clock edges keeps its toggle and commits nothing
      commit = cs_rise && seen_low_reg && flags_ref.armed &&
               (flags_ref.frame_tog != last_tog_reg) && (pstate_reg == R_IDLE);
      unique case (pstate_reg)
         R_IDLE: begin
            if (commit) begin
               if (opcode_reg == OP_SET_WRITE_LATCH) begin
                  latch_next = 1'b1;
               end else if (opcode_reg == OP_CLR_WRITE_LATCH) begin
                  latch_next = 1'b0;
               end else if (latch_reg && flags_ref.wp_n) begin
                  pstate_next = R_PROG;
                  cnt_next = TWC_CNT_W'(WRITE_CYCLES - 1);
                  if (opcode_reg == OP_WRITE_STATUS) begin
                     bp_next = pbuf_reg[0][ST_BP_LSB +: 2];
                  end else begin
                     for (int i = 0; i < PAGE_BYTES; i++) begin
                        if (valid_reg[i]) begin
                           mem_next[{page, 4'(i)}] = pbuf_reg[i];
                        end
                     end
                  end
               end
            end
            // protect low wins over a same-cycle latch set
            if (!flags_ref.wp_n) begin
               latch_next = 1'b0;
            end
         end
         R_PROG: begin
            // neither select nor protect stops a running cycle
            if (cnt_reg == '0) begin
               pstate_next = R_IDLE;
               latch_next = 1'b0;
            end else begin
               cnt_next = cnt_reg - TWC_CNT_W'(1);
            end
         end
      endcase
      busy_next = (pstate_next == R_PROG);
      standby_next = flags_ref.cs_n && (pstate_next == R_IDLE);
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         pstate_reg <= R_IDLE;
         cnt_reg <= '0;
         latch_reg <= 1'b0;
         bp_reg <= BP_RESET;
         busy_reg <= 1'b0;
         standby_reg <= 1'b0;
         seen_low_reg <= 1'b0;
         last_tog_reg <= 1'b0;
         cs_prev_reg <= 1'b0;
      end else begin
         pstate_reg <= pstate_next;
         cnt_reg <= cnt_next;
         latch_reg <= latch_next;
         bp_reg <= bp_next;
         busy_reg <= busy_next;
         standby_reg <= standby_next;
         seen_low_reg <= seen_low_next;
         last_tog_reg <= last_tog_next;
         cs_prev_reg <= cs_prev_next;
      end
   end

   // nonvolatile contents survive reset
   always_ff @(posedge I_REF_CLK) begin
      mem_reg <= mem_next;
   end

   assign O_SO = so_reg;
   assign O_SO_OE = oe_reg;
   assign O_WRITE_BUSY = busy_reg;
   assign O_WRITE_LATCH = latch_reg;
   assign O_STANDBY = standby_reg;

endmodule : serial_eeprom_pin_control

//--- pkg/eeprom_pin_pkg.sv
package eeprom_pin_pkg;

   // array geometry
   localparam int MEM_BYTES = 512;
   localparam int PAGE_BYTES = 16;

   // instruction codes
   localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06; // set_write_latch_cmd
   localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [2:0] OP_READ_LOW = 3'h3;
   localparam logic [2:0] OP_WRITE_LOW = 3'h2;

   // status byte field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_LATCH_BIT = 1;
   localparam int ST_BP_LSB = 2;

   // reset value and byte read while busy
   localparam logic [1:0] BP_RESET = 2'h0;
   localparam logic [7:0] READ_BUSY_BYTE = 8'hff;

   // self-timed write cycle
   localparam int REF_CLK_HZ = 10_000_000;
   localparam int TWC_MAX_MS = 5;
   localparam int TWC_CYCLES = TWC_MAX_MS * (REF_CLK_HZ / 1000);
   localparam int TWC_CNT_W = 16;

   // link-side phase of a serial sequence
   typedef enum logic [2:0] {
      L_CMD = 3'h0,
      L_ADDR = 3'h1,
      L_DIN = 3'h3,
      L_DOUT = 3'h2,
      L_STAT = 3'h6,
      L_WSR = 3'h7,
      L_IGN = 3'h5
   } link_state_e;

   typedef enum logic [0:0] {
      R_IDLE = 1'b0,
      R_PROG = 1'b1
   } prog_state_e;

   // levels passed from the link side to the reference side
   typedef struct packed {
      logic cs_n;
      logic wp_n;
      logic armed;
      logic frame_tog;
   } link_flags_s;

   // device state shown to the link side
   typedef struct packed {
      logic [1:0] bp;
      logic latch;
      logic busy;
   } dev_status_s;

   function automatic logic op_is_read(input logic [7:0] op);
      return (op[7:4] == 4'h0) && (op[2:0] == OP_READ_LOW);
   endfunction : op_is_read

   function automatic logic op_is_write(input logic [7:0] op);
      return (op[7:4] == 4'h0) && (op[2:0] == OP_WRITE_LOW);
   endfunction : op_is_write

endpackage : eeprom_pin_pkg

//--- hdl/level_sync2.sv
`timescale 1ns/10ps
module level_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule : level_sync2

//--- dv/eeprom_pin_checker.sv
`timescale 1ns/10ps
module eeprom_pin_checker #(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic I_SI,
   input wire logic I_HOLD_N,
   input wire logic I_WP_N,
   input wire logic O_SO,
   input wire logic O_SO_OE,
   input wire logic O_WRITE_BUSY,
   input wire logic O_WRITE_LATCH,
   input wire logic O_STANDBY
);
   int busy_cnt_reg;
   int busy_cnt_next;
   logic so_rise_reg;
   always_comb begin
      busy_cnt_next = O_WRITE_BUSY ? busy_cnt_reg + 1 : 0;
   end
   always_ff @(posedge I_REF_CLK) begin
      busy_cnt_reg <= I_RST_N ? busy_cnt_next : 0;
   end
   // so seen at the rising edge, compared at the next falling edge
   always_ff @(posedge I_SCK) begin
      so_rise_reg <= O_SO;
   end
   a_float_desel:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) I_CS_N |-> !O_SO_OE)
      else $error("so driven while deselected");
   a_hold_float:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) !I_HOLD_N |-> !O_SO_OE)
      else $error("so driven while paused");
   a_sel_active:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
         (!I_CS_N) [*5] |-> !O_STANDBY) else $error("standby while selected");
   a_standby_idle:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
         $rose(O_STANDBY) |-> $past(I_CS_N, 2) && !O_WRITE_BUSY) else $error("bad standby");
   a_busy_length:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) $fell(O_WRITE_BUSY) |->
         busy_cnt_reg inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]}) else $error("busy length");
   a_latch_at_end:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
         $fell(O_WRITE_BUSY) |-> ##[0:1] !O_WRITE_LATCH) else $error("latch kept");
   a_start_cause:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N) $rose(O_WRITE_BUSY) |->
         $past(O_WRITE_LATCH) && $past(I_CS_N)) else $error("write start without cause");
   a_wp_clears:
      assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
         (!I_WP_N) [*5] ##0 !O_WRITE_BUSY |-> !O_WRITE_LATCH) else $error("latch under wp");
   a_so_falling:
      assert property (@(negedge I_SCK) disable iff (!I_RST_N)
         O_SO_OE |-> O_SO == so_rise_reg) else $error("so moved while sck high");
endmodule : eeprom_pin_checker
bind serial_eeprom_pin_control eeprom_pin_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
   .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_SCK(I_SCK), .I_CS_N(I_CS_N),
   .I_SI(I_SI), .I_HOLD_N(I_HOLD_N), .I_WP_N(I_WP_N), .O_SO(O_SO), .O_SO_OE(O_SO_OE),
   .O_WRITE_BUSY(O_WRITE_BUSY), .O_WRITE_LATCH(O_WRITE_LATCH), .O_STANDBY(O_STANDBY));

//--- dv/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
   input wire logic i_ref_clk,
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   output logic o_hold_n
);
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];
   initial begin
      // start after time zero so the async clears see a real edge
      #1;
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_hold_n = 1'b1;
   end
   // sck only toggles inside a frame; si toggles once tx bytes run out
   task automatic xfer(input int nbits, input bit pause);
      logic [7:0] sh;
      int k;
      k = 0;
      rx_q = {};
      @(negedge i_ref_clk);
      o_cs_n = 1'b0;
      #40;
      for (int i = 0; i < nbits; i++) begin
         o_si = (i / 8 < tx_q.size()) ? tx_q[i / 8][7 - i % 8] : ~o_si;
         if (pause && i == 12) begin
            o_hold_n = 1'b0;
            #200 o_hold_n = 1'b1;
            #20;
         end
         #15 o_sck = 1'b1;
         if (i_so_oe === 1'b1) begin
            sh = {sh[6:0], i_so};
            k++;
            if (k % 8 == 0) rx_q.push_back(sh);
         end
         #15 o_sck = 1'b0;
      end
      #40;
      @(negedge i_ref_clk);
      o_cs_n = 1'b1;
      o_si = ~o_si;
      repeat (6) @(negedge i_ref_clk);
   endtask : xfer
endmodule : spi_host_model

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import eeprom_pin_pkg::*;
   localparam int WC = 20;
   logic ref_clk, rst_n, wp_n, sck, cs_n, si, hold_n;
   logic so, so_oe, busy, latch, stby;
   int miscompares = 0;
   int checks_done = 0;
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   serial_eeprom_pin_control #(.WRITE_CYCLES(WC)) u_dut (.I_REF_CLK(ref_clk), .I_RST_N(rst_n),
      .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si), .I_HOLD_N(hold_n), .I_WP_N(wp_n), .O_SO(so),
      .O_SO_OE(so_oe), .O_WRITE_BUSY(busy), .O_WRITE_LATCH(latch), .O_STANDBY(stby));
   spi_host_model u_host (.i_ref_clk(ref_clk), .i_so(so), .i_so_oe(so_oe), .o_sck(sck),
      .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n));
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_byte
   task automatic cmp_flag(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask : cmp_flag
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      cmp_flag(busy, lvl);
   endtask : wait_busy
   task automatic t_idle;
      cmp_flag(stby, 1'b1);
      cmp_flag(so_oe, 1'b0);
      cmp_flag(latch, 1'b0);
   endtask : t_idle
   task automatic t_latch;
      u_host.tx_q = '{OP_SET_WRITE_LATCH};
      u_host.xfer(7, 1'b0);
      cmp_flag(latch, 1'b0);
      u_host.xfer(8, 1'b0);
      cmp_flag(latch, 1'b1);
   endtask : t_latch
   task automatic t_partial;
      u_host.tx_q = '{8'h02, 8'h11, 8'hff};
      u_host.xfer(20, 1'b0);
      cmp_flag(busy, 1'b0);
      cmp_flag(latch, 1'b1);
   endtask : t_partial
   task automatic t_write;
      u_host.tx_q = '{8'h02, 8'h10, 8'ha5, 8'h3c};
      u_host.xfer(32, 1'b0);
      cmp_flag(busy, 1'b1);
      cmp_flag(stby, 1'b0);
      u_host.tx_q = '{OP_READ_STATUS};
      u_host.xfer(16, 1'b0);
      cmp_byte(u_host.rx_q[0] & 8'h03, 8'h03);
      wp_n = 1'b0;
      wait_busy(1'b0);
      wp_n = 1'b1;
      cmp_flag(latch, 1'b0);
      cmp_flag(stby, 1'b1);
      u_host.tx_q = '{8'h03, 8'h10};
      u_host.xfer(32, 1'b1);
      cmp_byte(u_host.rx_q[0], 8'ha5);
      cmp_byte(u_host.rx_q[1], 8'h3c);
   endtask : t_write
   task automatic t_wp;
      wp_n = 1'b0;
      u_host.tx_q = '{OP_SET_WRITE_LATCH};
      u_host.xfer(8, 1'b0);
      cmp_flag(latch, 1'b0);
      u_host.tx_q = '{8'h02, 8'h10, 8'h00};
      u_host.xfer(24, 1'b0);
      cmp_flag(busy, 1'b0);
      wp_n = 1'b1;
      u_host.tx_q = '{8'h03, 8'h10};
      u_host.xfer(24, 1'b0);
      cmp_byte(u_host.rx_q[0], 8'ha5);
   endtask : t_wp
   task automatic close_out;
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      // a real falling edge for the link-side async clear
      #1;
      rst_n = 1'b0;
      wp_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      t_idle();
      t_latch();
      t_partial();
      t_write();
      t_wp();
      close_out();
   end
   // whole run needs about 150 reference cycles
   initial begin
      #300000;
      miscompares++;
      close_out();
   end
endmodule : tb_top
